// ===== logic/tbw_map.svh
/*
  Constants for the table write instruction block: opcode pattern, widths,
  mode field position, timing. Assumes inclusion by bare name from logic/ files.
*/
`ifndef TBW_MAP_SVH
`define TBW_MAP_SVH

`define TBW_OPC_W        16
`define TBW_OPC_MASK     16'hFFFC
`define TBW_OPC_MATCH    16'h000C
`define TBW_PTR_W        21
`define TBW_LAT_W        8
`define TBW_MODE_LSB     0
`define TBW_MODE_W       2
`define TBW_CYCLES       2
`define TBW_HOLD_IDX_W   6

`endif

// ===== logic/tbw_pkg.sv
/*
  Types for the table write instruction block.
  Assumes tbw_map.svh is on the include path.
*/
`include "tbw_map.svh"

package tbw_pkg;

  typedef enum logic [1:0] {
    TBW_MODE_PLAIN   = 2'h0,
    TBW_MODE_POSTINC = 2'h1,
    TBW_MODE_POSTDEC = 2'h2,
    TBW_MODE_PREINC  = 2'h3
  } tbw_mode_t;

  typedef enum logic [0:0] {
    TBW_ST_IDLE  = 1'h0,
    TBW_ST_WRITE = 1'h1
  } tbw_state_t;

endpackage

// ===== logic/tbw_ptr_calc.sv
/*
  Pointer arithmetic for the table write block: address used for the
  holding-register write and the pointer value left behind.
  Assumes a purely combinational context, no clock.
*/
`timescale 1ns/1ps
`include "tbw_map.svh"

module tbw_ptr_calc
  import tbw_pkg::*;
#(
  parameter int PTR_W = `TBW_PTR_W
) (
  input  wire logic [PTR_W-1:0] ptr_i,
  input  tbw_pkg::tbw_mode_t    mode_i,
  output logic      [PTR_W-1:0] addr_o,
  output logic      [PTR_W-1:0] ptr_next_o
);

  logic [PTR_W-1:0] inc;
  logic [PTR_W-1:0] dec;

  assign inc = ptr_i + PTR_W'(1);
  assign dec = ptr_i - PTR_W'(1);

  always_comb begin
    addr_o     = ptr_i;
    ptr_next_o = ptr_i;
    case (mode_i)
      TBW_MODE_PLAIN: begin
        ptr_next_o = ptr_i;
      end
      TBW_MODE_POSTINC: begin
        ptr_next_o = inc;
      end
      TBW_MODE_POSTDEC: begin
        ptr_next_o = dec;
      end
      TBW_MODE_PREINC: begin
        addr_o     = inc;
        ptr_next_o = inc;
      end
      default: begin
        ptr_next_o = ptr_i;
      end
    endcase
  end

endmodule

// ===== logic/tbw_core.sv
/*
  Table write instruction execution: decodes the opcode, writes the table
  latch into the selected holding-register byte and updates the pointer.
  The instruction takes two cycles. The take cycle latches the mode, the
  table pointer and the table latch; the execute cycle shows busy_o, and
  at its closing edge one holding-register write strobe and one table
  pointer load strobe are registered out together.
  Nothing here programs nonvolatile memory; the holding bytes wait for a
  separate, later write sequence.
  Assumes the core presents a decoded opcode with a one-cycle valid strobe,
  that an instruction offered while busy_o is high may be dropped, and
  that pointer and latch inputs come from logic on the same clock, so they
  pass no synchroniser. Assumes the core loads table_pointer_o into its
  pointer on table_pointer_wr_o, and the holding registers take
  hold_data_o at hold_idx_o on hold_wr_o.
*/
`timescale 1ns/1ps
`include "tbw_map.svh"

module tbw_core
  import tbw_pkg::*;
#(
  parameter int PTR_W  = `TBW_PTR_W,
  parameter int LAT_W  = `TBW_LAT_W,
  parameter int HIDX_W = `TBW_HOLD_IDX_W
) (
  input  wire logic                   mclk_i,
  input  wire logic                   nrst_i,
  input  wire logic [`TBW_OPC_W-1:0]  opcode_i,
  input  wire logic                   opcode_valid_i,
  input  wire logic [PTR_W-1:0]       table_pointer_i,
  input  wire logic [LAT_W-1:0]       table_latch_i,
  output logic                        busy_o,
  output logic                        hold_wr_o,
  output logic      [HIDX_W-1:0]      hold_idx_o,
  output logic      [LAT_W-1:0]       hold_data_o,
  output logic                        table_pointer_wr_o,
  output logic      [PTR_W-1:0]       table_pointer_o,
  output logic                        nvm_program_o
);

  import tbw_pkg::*;

  // Opcode match on the fixed bits; the low two bits are the mode
  function automatic logic is_table_write_instr(
    input logic [`TBW_OPC_W-1:0] op
  );
    is_table_write_instr = (op & `TBW_OPC_MASK) == `TBW_OPC_MATCH;
  endfunction

  function automatic tbw_mode_t mode_of(
    input logic [`TBW_OPC_W-1:0] op
  );
    mode_of = tbw_mode_t'(op[`TBW_MODE_LSB +: `TBW_MODE_W]);
  endfunction

  tbw_state_t        state_reg;
  tbw_state_t        state_next;
  tbw_mode_t         mode_reg;
  tbw_mode_t         mode_next;
  logic [PTR_W-1:0]  ptr_reg;
  logic [PTR_W-1:0]  ptr_next;
  logic [LAT_W-1:0]  lat_reg;
  logic [LAT_W-1:0]  lat_next;
  logic              wr_reg;
  logic              wr_next;
  logic [HIDX_W-1:0] idx_reg;
  logic [HIDX_W-1:0] idx_next;
  logic [LAT_W-1:0]  data_reg;
  logic [LAT_W-1:0]  data_next;
  logic              pwr_reg;
  logic              pwr_next;
  logic [PTR_W-1:0]  pout_reg;
  logic [PTR_W-1:0]  pout_next;
  logic [PTR_W-1:0]  calc_addr;
  logic [PTR_W-1:0]  calc_ptr;
  logic              take;

  // Only an idle block takes; an opcode offered while busy is dropped
  assign take = opcode_valid_i && (state_reg == TBW_ST_IDLE) &&
                is_table_write_instr(opcode_i);

  tbw_ptr_calc #(
    .PTR_W (PTR_W)
  ) u_calc (
    .ptr_i      (ptr_reg),
    .mode_i     (mode_reg),
    .addr_o     (calc_addr),
    .ptr_next_o (calc_ptr)
  );

  // Sequencer: take cycle, then one execute cycle; a new instruction may
  // be taken in the cycle right after busy_o falls
  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    case (state_reg)
      TBW_ST_IDLE: begin
        if (take) begin
          mode_next  = mode_of(opcode_i);
          state_next = TBW_ST_WRITE;
        end
      end
      TBW_ST_WRITE: begin
        state_next = TBW_ST_IDLE;
      end
      default: begin
        state_next = TBW_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_reg <= TBW_ST_IDLE;
      mode_reg  <= TBW_MODE_PLAIN;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
    end
  end

  // Operands are frozen at the take edge; later input changes are ignored
  always_comb begin
    ptr_next = ptr_reg;
    lat_next = lat_reg;
    case (state_reg)
      TBW_ST_IDLE: begin
        if (take) begin
          ptr_next = table_pointer_i;
          lat_next = table_latch_i;
        end
      end
      default: begin
        lat_next = lat_reg;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      ptr_reg <= '0;
      lat_reg <= '0;
    end else begin
      ptr_reg <= ptr_next;
      lat_reg <= lat_next;
    end
  end

  // Holding write: the strobe lasts one cycle; index and data hold until
  // the next write, so the far side may sample them late
  always_comb begin
    wr_next   = 1'b0;
    idx_next  = idx_reg;
    data_next = data_reg;
    case (state_reg)
      TBW_ST_WRITE: begin
        wr_next   = 1'b1;
        // Only the low index bits reach the holding buffer
        idx_next  = calc_addr[HIDX_W-1:0];
        data_next = lat_reg;
      end
      default: begin
        wr_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      wr_reg   <= 1'b0;
      idx_reg  <= '0;
      data_reg <= '0;
    end else begin
      wr_reg   <= wr_next;
      idx_reg  <= idx_next;
      data_reg <= data_next;
    end
  end

  // Pointer load in every mode; plain mode reloads the same value, so the
  // core sees one strobe shape whatever the mode
  always_comb begin
    pwr_next  = 1'b0;
    pout_next = pout_reg;
    case (state_reg)
      TBW_ST_WRITE: begin
        pwr_next  = 1'b1;
        pout_next = calc_ptr;
      end
      default: begin
        pwr_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pwr_reg  <= 1'b0;
      pout_reg <= '0;
    end else begin
      pwr_reg  <= pwr_next;
      pout_reg <= pout_next;
    end
  end

  // Busy is a decode of the state register, high in the execute cycle
  assign busy_o             = (state_reg != TBW_ST_IDLE);

  assign hold_wr_o          = wr_reg;
  assign hold_idx_o         = idx_reg;
  assign hold_data_o        = data_reg;
  assign table_pointer_wr_o = pwr_reg;
  assign table_pointer_o    = pout_reg;
  // Programming is left to a separate sequence outside this block
  assign nvm_program_o      = 1'b0;

endmodule

// ===== tb/tbw_properties.sv
/* Assertions on the tbw_core ports, bound below the module.
   Assumes the core's default widths. */
`timescale 1ns/1ps
module tbw_properties (
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic [15:0] opcode_i,
  input wire logic        opcode_valid_i,
  input wire logic [20:0] table_pointer_i,
  input wire logic [7:0]  table_latch_i,
  input wire logic        busy_o,
  input wire logic        hold_wr_o,
  input wire logic [5:0]  hold_idx_o,
  input wire logic [7:0]  hold_data_o,
  input wire logic [20:0] table_pointer_o,
  input wire logic        nvm_program_o
);
  wire         tk = opcode_valid_i && !busy_o && opcode_i[15:2] == 14'h0003;
  wire  [1:0]  md = opcode_i[1:0];
  logic [20:0] p1;
  logic [20:0] p2;
  logic [20:0] p2i;
  assign p2i = p2 + 21'h1;
  // Pointer as it stood at the take edge, two edges back
  always_ff @(posedge mclk_i) p1 <= table_pointer_i;
  always_ff @(posedge mclk_i) p2 <= p1;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  property p_pl; tk && md == 2'h0 |-> ##2 hold_wr_o && table_pointer_o == p2
    && hold_data_o == $past(table_latch_i, 2); endproperty
  a_pl: assert property (p_pl) else $error("plain write wrong");
  property p_pi; tk && md == 2'h1 |-> ##2 table_pointer_o == p2 + 21'h1
    && hold_idx_o == p2[5:0]; endproperty
  a_pi: assert property (p_pi) else $error("postinc wrong");
  property p_pd; tk && md == 2'h2 |-> ##2 table_pointer_o == p2 - 21'h1
    && hold_idx_o == p2[5:0]; endproperty
  a_pd: assert property (p_pd) else $error("postdec wrong");
  property p_pr; tk && md == 2'h3 |-> ##2 table_pointer_o == p2i
    && hold_idx_o == p2i[5:0]; endproperty
  a_pr: assert property (p_pr) else $error("preinc wrong");
  property p_dc; hold_wr_o |-> $past(tk, 2); endproperty
  a_dc: assert property (p_dc) else $error("write without take");
  property p_nv; !nvm_program_o; endproperty
  a_nv: assert property (p_nv) else $error("programming seen");
endmodule
bind tbw_core tbw_properties tbw_properties_i (
  .mclk_i, .nrst_i, .opcode_i, .opcode_valid_i, .table_pointer_i,
  .table_latch_i, .busy_o, .hold_wr_o, .hold_idx_o, .hold_data_o,
  .table_pointer_o, .nvm_program_o);

// ===== tb/tbw_hold_model.sv
/* Holding-register bytes written by the core's write strobe.
   Assumes the core's default index and data widths. */
`timescale 1ns/1ps
module tbw_hold_model (
  input wire logic       mclk_i,
  input wire logic       wr_i,
  input wire logic [5:0] idx_i,
  input wire logic [7:0] data_i
);
  logic [7:0] mem [64];
  // Bytes only wait here; programming is a later, separate sequence
  always @(posedge mclk_i) if (wr_i) mem[idx_i] <= data_i;
endmodule

// ===== tb/tb.sv
/* Self-checking bench for tbw_core with a holding-register model.
   Assumes the logic files and the checker compile first. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
module tb;
  logic        mclk_i = 1'b0, nrst_i = 1'b0, opcode_valid_i = 1'b0;
  logic [15:0] opcode_i = 16'h0;
  logic [20:0] table_pointer_i = 21'h0, table_pointer_o;
  logic [7:0]  table_latch_i = 8'h0, hold_data_o;
  logic [5:0]  hold_idx_o;
  logic        busy_o, hold_wr_o, table_pointer_wr_o, nvm_program_o;
  logic [34:0] q[$], e;
  logic [31:0] r;
  int          err_count = 0, n_checks = 0, seed = 23, i;
  always #25 mclk_i = ~mclk_i;
  tbw_core tbw_core_i (.*);
  tbw_hold_model tbw_hold_model_i (.mclk_i, .wr_i(hold_wr_o),
    .idx_i(hold_idx_o), .data_i(hold_data_o));
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // v holds pointer in [28:8], latch in [7:0]; w keeps valid up while busy
  task automatic go(input logic [15:0] op, input logic [31:0] v,
                    input logic w);
    logic [20:0] n;
    n = op[1:0] == 2'h2 ? v[28:8] - 21'h1 : v[28:8] + {20'h0, |op[1:0]};
    @(negedge mclk_i);
    {opcode_valid_i, opcode_i, table_pointer_i, table_latch_i} =
      {1'b1, op, v[28:0]};
    if (op[15:2] == 14'h0003)
      q.push_back({op[1:0] == 2'h3 ? n[5:0] : v[13:8], v[7:0], n});
    @(negedge mclk_i);
    `CHK(busy_o, op[15:2] == 14'h0003)
    opcode_valid_i = w;
  endtask
  always @(negedge mclk_i) if (hold_wr_o === 1'b1) begin
    `CHK(q.size() > 0, 1'b1)
    e = q.pop_front();
    `CHK({hold_idx_o, hold_data_o, table_pointer_o}, e)
    `CHK(table_pointer_wr_o, 1'b1)
  end
  initial begin
    repeat (3) @(negedge mclk_i);
    nrst_i = 1'b1;
    `CHK({busy_o, hold_wr_o, table_pointer_wr_o}, 3'h0)
    `CHK({table_pointer_o, hold_idx_o, hold_data_o}, 35'h0)
    go(16'h000D, 32'h00A35655, 1'b0);
    repeat (2) @(negedge mclk_i);
    `CHK(tbw_hold_model_i.mem[22], 8'h55)
    $display("test walk done");
    go(16'h000F, 32'h01389A34, 1'b0);
    go(16'h000D, 32'h1FFFFFA5, 1'b0);
    go(16'h000E, 32'h0000005A, 1'b1);
    go(16'h000C, 32'h00001234, 1'b0);
    $display("test edges done");
    for (i = 0; i < 64; i++) begin
      r = $random(seed);
      go({14'h0003, r[31:30]}, r, r[29]);
      go(i[0] ? r[15:0] | 16'h0100 : {14'h0002, r[1:0]}, r, 1'b0);
    end
    $display("test random done");
    for (i = 0; i < 8 && q.size() > 0; i++) @(negedge mclk_i);
    `CHK(q.size(), 0)
    summarize();
  end
endmodule
